/* File: logic/dcr_defs.svh */
// Register offsets, field positions, reset values and line counts of the decoder control bank
`ifndef DCR_DEFS_SVH
`define DCR_DEFS_SVH

`define DCR_OFS_SYNC_WIN 8'h17
`define DCR_OFS_VERTICAL_BLANK_START_OFFSET 8'h18
`define DCR_OFS_VERTICAL_BLANK_STOP_OFFSET 8'h19
`define DCR_OFS_CHROMA_ONE 8'h1a
`define DCR_OFS_CHROMA_TWO 8'h1b
`define DCR_OFS_IRQ_CLR_B 8'h1c

`define DCR_RST_SYNC_WIN 8'h52
`define DCR_RST_VERTICAL_BLANK_START_OFFSET 8'h00
`define DCR_RST_VERTICAL_BLANK_STOP_OFFSET 8'h00
`define DCR_RST_CHROMA_ONE 8'h0c
`define DCR_RST_CHROMA_TWO 8'h14

`define DCR_BIT_UNS_EAV 0
`define DCR_BIT_UNS_SAV 1
`define DCR_BIT_UNS_ANC 2
`define DCR_BIT_SCL_EAV 3
`define DCR_BIT_SCL_SAV 4
`define DCR_BIT_SCL_ANC 5
`define DCR_BIT_SCALER_POWER_DOWN 6
`define DCR_BIT_PLL_RESET 5
`define DCR_BIT_ADAPT_COMB 3
`define DCR_BIT_COMB 2
`define DCR_BIT_WIDEBAND 2

`define DCR_SYNC_WIN_MASK 8'h7f
`define DCR_CHROMA_ONE_MASK 8'h3f
`define DCR_CHROMA_TWO_MASK 8'h07
`define DCR_IRQ_B_MASK 8'h9f

`define DCR_STD_LINES_A 10'd525
`define DCR_STD_LINES_B 10'd625

`endif

/* File: logic/dcr_pkg.sv */
// Types shared by the decoder control bank
package dcr_pkg;

   typedef enum logic [1:0] {
      DCR_GAIN_ON,
      DCR_GAIN_RESERVED,
      DCR_GAIN_OFF,
      DCR_GAIN_FROZEN
   } dcr_gain_e;

   typedef struct packed {
      logic incl_eav;
      logic incl_sav;
      logic excl_anc;
   } dcr_win_s;

   typedef struct packed {
      logic sw_init;
      logic field_rate;
      logic line_alt;
      logic color_lock;
      logic sync_lock;
   } dcr_events_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dcr_req_s;

endpackage

/* File: logic/dcr_src_detect.sv */
// Broadcast / recorder source type detector from lines per frame
`include "dcr_defs.svh"

module dcr_src_detect #(
   parameter logic [9:0] STD_LINES_A = `DCR_STD_LINES_A,
   parameter logic [9:0] STD_LINES_B = `DCR_STD_LINES_B
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Video timing strobes
   input wire logic line_strobe_i,
   input wire logic frame_strobe_i,
   // Result
   output logic recorder_o,
   output logic change_o
);

   logic [9:0] cnt_q, cnt_d;
   logic rec_q, rec_d;
   logic chg_q, chg_d;

   always_comb
   begin
      cnt_d = cnt_q;
      rec_d = rec_q;
      chg_d = 1'b0;
      if (frame_strobe_i)
      begin
         // Nonstandard line total means a recorder source
         rec_d = (cnt_q != STD_LINES_A) && (cnt_q != STD_LINES_B);
         chg_d = rec_d != rec_q;
         cnt_d = line_strobe_i ? 10'h001 : 10'h000;
      end
      else if (line_strobe_i && cnt_q != 10'h3ff)
      begin
         // Saturates so a lost frame strobe cannot alias to a standard count
         cnt_d = cnt_q + 10'h001;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         cnt_q <= 10'h000;
         rec_q <= 1'b0;
         chg_q <= 1'b0;
      end
      else if (ce_i)
      begin
         cnt_q <= cnt_d;
         rec_q <= rec_d;
         chg_q <= chg_d;
      end
   end

   assign recorder_o = rec_q;
   assign change_o = chg_q;

   AST_SRC_CHANGE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && $changed(rec_q) |-> chg_q)
      else $error("Source type changed without change pulse");

endmodule // dcr_src_detect

/* File: logic/dcr_regs.sv */
// Per-channel decoder output, chroma and interrupt-clear control register bank
`include "dcr_defs.svh"

module dcr_regs #(
   parameter int LINE_W = 10
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Register access from the two-wire bus front end
   input wire dcr_pkg::dcr_req_s req_i,
   output logic [7:0] rdata_o,
   // Status events and video timing
   input wire dcr_pkg::dcr_events_s events_i,
   input wire logic line_strobe_i,
   input wire logic frame_strobe_i,
   input wire logic [LINE_W-1:0] line_num_i,
   input wire logic [LINE_W-1:0] std_vblank_start_i,
   input wire logic [LINE_W-1:0] std_vblank_stop_i,
   input wire logic gp_pin_vblank_mode_i,
   // Output window and scaler control
   output dcr_pkg::dcr_win_s unscaled_window_o,
   output dcr_pkg::dcr_win_s scaled_window_o,
   output logic scaler_power_down_o,
   // Blanking
   output logic [LINE_W:0] vblank_start_line_o,
   output logic [LINE_W:0] vblank_stop_line_o,
   output logic vertical_blank_output_o,
   output logic luma_bypass_active_o,
   // Chroma
   output logic chroma_pll_reset_o,
   output logic genlock_reset_flag_o,
   output logic adaptive_comb_enable_o,
   output logic comb_enable_o,
   output dcr_pkg::dcr_gain_e auto_chroma_gain_o,
   output logic wideband_chroma_filter_o,
   output logic [2:0] chroma_bw_sel_o,
   // Status
   output logic [7:0] irq_status_b_o,
   output logic source_type_o
);

   // Sign-extends a line offset to the adjusted-line width
   function automatic logic [LINE_W:0] adj_line(input logic [LINE_W-1:0] std, input logic [7:0] ofs);
      logic [LINE_W:0] ext;
      ext = {{(LINE_W - 7){ofs[7]}}, ofs};
      return {1'b0, std} + ext;
   endfunction

   function automatic dcr_pkg::dcr_gain_e gain_dec(input logic [1:0] f);
      unique case (f)
         2'b00: gain_dec = dcr_pkg::DCR_GAIN_ON;
         2'b01: gain_dec = dcr_pkg::DCR_GAIN_RESERVED;
         2'b10: gain_dec = dcr_pkg::DCR_GAIN_OFF;
         2'b11: gain_dec = dcr_pkg::DCR_GAIN_FROZEN;
      endcase
   endfunction

   logic [7:0] win_q, win_d;
   logic [7:0] vbs_q, vbs_d;
   logic [7:0] vbe_q, vbe_d;
   logic [7:0] chr1_q, chr1_d;
   logic [7:0] chr2_q, chr2_d;
   logic [7:0] stat_q, stat_d;
   logic [7:0] rdata_q, rdata_d;
   logic [LINE_W:0] vstart_q, vstart_d;
   logic [LINE_W:0] vstop_q, vstop_d;
   logic vbo_q, vbo_d;
   logic bypass_q, bypass_d;
   logic src_rec;
   logic src_chg;
   logic in_blank;
   logic [7:0] clr_b;
   logic [7:0] set_b;

   dcr_src_detect u_src_detect (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .line_strobe_i(line_strobe_i),
      .frame_strobe_i(frame_strobe_i),
      .recorder_o(src_rec),
      .change_o(src_chg)
   );

   // Register writes and status
   always_comb
   begin
      win_d = win_q;
      vbs_d = vbs_q;
      vbe_d = vbe_q;
      chr1_d = chr1_q;
      chr2_d = chr2_q;
      clr_b = 8'h00;
      if (req_i.wr)
      begin
         unique case (req_i.addr)
            `DCR_OFS_SYNC_WIN: win_d = req_i.wdata & `DCR_SYNC_WIN_MASK;
            `DCR_OFS_VERTICAL_BLANK_START_OFFSET: vbs_d = req_i.wdata;
            `DCR_OFS_VERTICAL_BLANK_STOP_OFFSET: vbe_d = req_i.wdata;
            `DCR_OFS_CHROMA_ONE: chr1_d = req_i.wdata & `DCR_CHROMA_ONE_MASK;
            `DCR_OFS_CHROMA_TWO: chr2_d = (`DCR_RST_CHROMA_TWO & ~`DCR_CHROMA_TWO_MASK)
               | (req_i.wdata & `DCR_CHROMA_TWO_MASK);
            // Strobe only: nothing is stored for this address
            `DCR_OFS_IRQ_CLR_B: clr_b = req_i.wdata & `DCR_IRQ_B_MASK;
            default: clr_b = 8'h00;
         endcase
      end
      set_b = {events_i.sw_init, 2'b00, events_i.field_rate, events_i.line_alt,
               events_i.color_lock, events_i.sync_lock, src_chg};
      // An event in the clearing cycle survives: set wins over clear
      stat_d = ((stat_q & ~clr_b) | set_b) & `DCR_IRQ_B_MASK;
   end

   // Read data; the clear register reads zero
   always_comb
   begin
      rdata_d = rdata_q;
      if (req_i.rd)
      begin
         unique case (req_i.addr)
            `DCR_OFS_SYNC_WIN: rdata_d = win_q;
            `DCR_OFS_VERTICAL_BLANK_START_OFFSET: rdata_d = vbs_q;
            `DCR_OFS_VERTICAL_BLANK_STOP_OFFSET: rdata_d = vbe_q;
            `DCR_OFS_CHROMA_ONE: rdata_d = chr1_q;
            `DCR_OFS_CHROMA_TWO: rdata_d = chr2_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // Blanking window; a start past the stop wraps over the frame end
   always_comb
   begin
      vstart_d = adj_line(std_vblank_start_i, vbs_q);
      vstop_d = adj_line(std_vblank_stop_i, vbe_q);
      if (vstart_q <= vstop_q)
         in_blank = ({1'b0, line_num_i} >= vstart_q) && ({1'b0, line_num_i} < vstop_q);
      else
         in_blank = ({1'b0, line_num_i} >= vstart_q) || ({1'b0, line_num_i} < vstop_q);
      vbo_d = in_blank && gp_pin_vblank_mode_i;
      bypass_d = in_blank;
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         win_q <= `DCR_RST_SYNC_WIN;
         vbs_q <= `DCR_RST_VERTICAL_BLANK_START_OFFSET;
         vbe_q <= `DCR_RST_VERTICAL_BLANK_STOP_OFFSET;
         chr1_q <= `DCR_RST_CHROMA_ONE;
         chr2_q <= `DCR_RST_CHROMA_TWO;
         stat_q <= 8'h00;
         rdata_q <= 8'h00;
         vstart_q <= '0;
         vstop_q <= '0;
         vbo_q <= 1'b0;
         bypass_q <= 1'b0;
      end
      else if (ce_i)
      begin
         win_q <= win_d;
         vbs_q <= vbs_d;
         vbe_q <= vbe_d;
         chr1_q <= chr1_d;
         chr2_q <= chr2_d;
         stat_q <= stat_d;
         rdata_q <= rdata_d;
         vstart_q <= vstart_d;
         vstop_q <= vstop_d;
         vbo_q <= vbo_d;
         bypass_q <= bypass_d;
      end
   end

   // Outputs are register bits; decoding below is wiring only
   assign rdata_o = rdata_q;
   assign unscaled_window_o = {win_q[`DCR_BIT_UNS_EAV], win_q[`DCR_BIT_UNS_SAV], win_q[`DCR_BIT_UNS_ANC]};
   assign scaled_window_o = {win_q[`DCR_BIT_SCL_EAV], win_q[`DCR_BIT_SCL_SAV], win_q[`DCR_BIT_SCL_ANC]};
   assign scaler_power_down_o = win_q[`DCR_BIT_SCALER_POWER_DOWN];
   assign vblank_start_line_o = vstart_q;
   assign vblank_stop_line_o = vstop_q;
   assign vertical_blank_output_o = vbo_q;
   assign luma_bypass_active_o = bypass_q;
   // PLL held in reset while the bit stays set, so software writes 0 to release it
   assign chroma_pll_reset_o = chr1_q[`DCR_BIT_PLL_RESET];
   assign genlock_reset_flag_o = chr1_q[`DCR_BIT_PLL_RESET];
   assign adaptive_comb_enable_o = chr1_q[`DCR_BIT_ADAPT_COMB];
   assign comb_enable_o = chr1_q[`DCR_BIT_COMB];
   assign auto_chroma_gain_o = gain_dec(chr1_q[1:0]);
   assign wideband_chroma_filter_o = chr2_q[`DCR_BIT_WIDEBAND];
   assign chroma_bw_sel_o = chr2_q[2:0];
   assign irq_status_b_o = stat_q;
   assign source_type_o = src_rec;

   sequence wr_to(logic [7:0] a);
      ce_i && req_i.wr && req_i.addr == a;
   endsequence

   AST_UNSCALED_WIN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_to(`DCR_OFS_SYNC_WIN) |=> unscaled_window_o == {$past(req_i.wdata[0]), $past(req_i.wdata[1]),
                                                         $past(req_i.wdata[2])})
      else $error("Unscaled window does not follow write");

   AST_SCALED_WIN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_to(`DCR_OFS_SYNC_WIN) |=> scaled_window_o == {$past(req_i.wdata[3]), $past(req_i.wdata[4]),
                                                       $past(req_i.wdata[5])})
      else $error("Scaled window does not follow write");

   AST_SCALER_POWER_DOWN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_to(`DCR_OFS_SYNC_WIN) ##1 (ce_i && !req_i.wr)[*2] |-> scaler_power_down_o == $past(req_i.wdata[6], 2))
      else $error("Scaler power down lost");

   AST_VERTICAL_BLANK_START_OFFSET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i ##1 ce_i |-> vblank_start_line_o == adj_line($past(std_vblank_start_i), $past(vbs_q)))
      else $error("Adjusted blank start wrong");

   AST_VERTICAL_BLANK_STOP_OFFSET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i ##1 ce_i |-> vblank_stop_line_o == adj_line($past(std_vblank_stop_i), $past(vbe_q)))
      else $error("Adjusted blank stop wrong");

   AST_VERTICAL_BLANK_OUTPUT_PIN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i ##1 ce_i |-> vertical_blank_output_o == (luma_bypass_active_o && $past(gp_pin_vblank_mode_i)))
      else $error("Blank pin does not follow window and pin mode");

   AST_PLL_RESET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_to(`DCR_OFS_CHROMA_ONE) ##0 req_i.wdata[5] |=> chroma_pll_reset_o && genlock_reset_flag_o)
      else $error("PLL reset not raised");

   AST_COMB: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_to(`DCR_OFS_CHROMA_ONE) |=> {adaptive_comb_enable_o, comb_enable_o} == $past(req_i.wdata[3:2]))
      else $error("Comb enables do not follow write");

   AST_GAIN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_to(`DCR_OFS_CHROMA_ONE) ##0 (req_i.wdata[1:0] == 2'b11) |=>
         auto_chroma_gain_o == dcr_pkg::DCR_GAIN_FROZEN)
      else $error("Gain hold not decoded");

   AST_BW_SEL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_to(`DCR_OFS_CHROMA_TWO) |=> chroma_bw_sel_o == $past(req_i.wdata[2:0]))
      else $error("Bandwidth select does not follow write");

   AST_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_to(`DCR_OFS_IRQ_CLR_B) ##0 (req_i.wdata[2] && !events_i.color_lock) |=> !irq_status_b_o[2])
      else $error("Status bit not cleared");

   AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && events_i.sync_lock |=> irq_status_b_o[1])
      else $error("Event lost");

   AST_RESERVED: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      irq_status_b_o[6:5] == 2'b00)
      else $error("Reserved status bits set");

   AST_KEEP_ZERO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_to(`DCR_OFS_IRQ_CLR_B) ##0 (!req_i.wdata[4] && irq_status_b_o[4]) |=> irq_status_b_o[4])
      else $error("Zero write cleared status");

   AST_PLL_RELEASE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_to(`DCR_OFS_CHROMA_ONE) ##0 !req_i.wdata[5] |=> !chroma_pll_reset_o && !genlock_reset_flag_o)
      else $error("PLL reset not released");

   AST_GAIN_OFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_to(`DCR_OFS_CHROMA_ONE) ##0 (req_i.wdata[1:0] == 2'b10) |=> auto_chroma_gain_o == dcr_pkg::DCR_GAIN_OFF)
      else $error("Gain off not decoded");

   AST_WIDEBAND: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_to(`DCR_OFS_CHROMA_TWO) |=> wideband_chroma_filter_o == $past(req_i.wdata[2]))
      else $error("Wideband enable does not follow write");

   // Source change pulse is one cycle wide, so it must land in status at once
   AST_SRC_STATUS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && src_chg |=> irq_status_b_o[0])
      else $error("Source change not recorded");

   sequence rd_of(logic [7:0] a);
      ce_i && req_i.rd && req_i.addr == a;
   endsequence

   // A stored strobe would read back and clear bits again on the next write
   AST_CLR_READS_ZERO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      rd_of(`DCR_OFS_IRQ_CLR_B) |=> rdata_o == 8'h00)
      else $error("Clear register read back nonzero");

   // Frozen state lets the host stop the pixel domain without losing settings
   AST_FREEZE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !ce_i |=> $stable(win_q) && $stable(chr1_q) && $stable(chr2_q) && $stable(stat_q))
      else $error("State moved while clock enable low");

endmodule // dcr_regs

/* File: test/dcr_host_model.sv */
// Host model issuing single-byte register accesses to the control bank
module dcr_host_model (
   // Clock
   input wire logic clk_i,
   // Decoded byte request towards the bank
   output dcr_pkg::dcr_req_s req_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial req_o = '0;

   // One byte per strobe; device addressing stays in the bus front end
   // Clearing status means writing ones only where a bit is to be cleared
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk_i);
      // Released lines show a changed pattern so a stale value is never mistaken for a request
      req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
endmodule // dcr_host_model

/* File: test/dcr_regs_bench.sv */
// Self-checking bench of the decoder control register bank
module dcr_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic ce_i = 1'b1;
   dcr_pkg::dcr_req_s req_i;
   logic [7:0] rdata_o;
   dcr_pkg::dcr_events_s events_i = '0;
   logic line_strobe_i = 1'b0;
   logic frame_strobe_i = 1'b0;
   logic [9:0] line_num_i = '0;
   logic [9:0] std_vblank_start_i = '0;
   logic [9:0] std_vblank_stop_i = '0;
   logic gp_pin_vblank_mode_i = 1'b0;
   dcr_pkg::dcr_win_s unscaled_window_o;
   dcr_pkg::dcr_win_s scaled_window_o;
   logic scaler_power_down_o;
   logic [10:0] vblank_start_line_o;
   logic [10:0] vblank_stop_line_o;
   logic vertical_blank_output_o;
   logic luma_bypass_active_o;
   logic chroma_pll_reset_o;
   logic genlock_reset_flag_o;
   logic adaptive_comb_enable_o;
   logic comb_enable_o;
   dcr_pkg::dcr_gain_e auto_chroma_gain_o;
   logic wideband_chroma_filter_o;
   logic [2:0] chroma_bw_sel_o;
   logic [7:0] irq_status_b_o;
   logic source_type_o;
   int mismatches = 0;
   int n_checks = 0;

   // Control outputs gathered: pd, unscaled, scaled, pll, genlock, ace, comb, gain, bandwidth
   wire logic [15:0] obs = {scaler_power_down_o, unscaled_window_o, scaled_window_o, chroma_pll_reset_o,
      genlock_reset_flag_o, adaptive_comb_enable_o, comb_enable_o, auto_chroma_gain_o, chroma_bw_sel_o};

   // Row layout: address, write data, read back, control outputs after the write
   localparam logic [39:0] ROWS [14] = '{40'h17_0e_0e_3864, 40'h17_71_71_c664, 40'h17_ff_7f_fe64,
      40'h1a_20_20_ff84, 40'h1a_0a_0a_fe54, 40'h1a_ff_3f_fffc, 40'h1a_01_01_fe0c, 40'h1b_00_10_fe08,
      40'h1b_ff_17_fe0f, 40'h1b_03_13_fe0b, 40'h18_80_80_fe0b, 40'h19_7f_7f_fe0b, 40'h1c_ff_00_fe0b,
      40'h30_55_00_fe0b};
   localparam logic [7:0] RST [5] = '{8'h52, 8'h00, 8'h00, 8'h0c, 8'h14};

   always #2 clk_i = ~clk_i;

   dcr_host_model host (
      .clk_i(clk_i),
      .req_o(req_i)
   );

   dcr_regs #(
      .LINE_W(10)
   ) uut (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .req_i(req_i),
      .rdata_o(rdata_o),
      .events_i(events_i),
      .line_strobe_i(line_strobe_i),
      .frame_strobe_i(frame_strobe_i),
      .line_num_i(line_num_i),
      .std_vblank_start_i(std_vblank_start_i),
      .std_vblank_stop_i(std_vblank_stop_i),
      .gp_pin_vblank_mode_i(gp_pin_vblank_mode_i),
      .unscaled_window_o(unscaled_window_o),
      .scaled_window_o(scaled_window_o),
      .scaler_power_down_o(scaler_power_down_o),
      .vblank_start_line_o(vblank_start_line_o),
      .vblank_stop_line_o(vblank_stop_line_o),
      .vertical_blank_output_o(vertical_blank_output_o),
      .luma_bypass_active_o(luma_bypass_active_o),
      .chroma_pll_reset_o(chroma_pll_reset_o),
      .genlock_reset_flag_o(genlock_reset_flag_o),
      .adaptive_comb_enable_o(adaptive_comb_enable_o),
      .comb_enable_o(comb_enable_o),
      .auto_chroma_gain_o(auto_chroma_gain_o),
      .wideband_chroma_filter_o(wideband_chroma_filter_o),
      .chroma_bw_sel_o(chroma_bw_sel_o),
      .irq_status_b_o(irq_status_b_o),
      .source_type_o(source_type_o)
   );

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.access(1'b1, a, d);
      #1;
   endtask

   task automatic rd(input logic [7:0] a);
      host.access(1'b0, a, 8'h00);
      #1;
   endtask

   task automatic do_reset;
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      #1;
   endtask

   task automatic pulse_ev(input logic [4:0] v);
      @(posedge clk_i);
      events_i <= v;
      @(posedge clk_i);
      events_i <= '0;
      #1;
   endtask

   // Lines are strobed every other cycle so each strobe is a clean pulse
   task automatic frame(input int n);
      repeat (n)
      begin
         @(posedge clk_i);
         line_strobe_i <= 1'b1;
         @(posedge clk_i);
         line_strobe_i <= 1'b0;
      end
      @(posedge clk_i);
      frame_strobe_i <= 1'b1;
      @(posedge clk_i);
      frame_strobe_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
   endtask

   task automatic vb(input logic [9:0] s, input logic [9:0] e, input logic [9:0] n, input logic m);
      @(posedge clk_i);
      std_vblank_start_i <= s;
      std_vblank_stop_i <= e;
      line_num_i <= n;
      gp_pin_vblank_mode_i <= m;
      repeat (3) @(posedge clk_i);
      #1;
   endtask

   // Guards against a hang anywhere in the main sequence
   initial
   begin
      repeat (50000) @(posedge clk_i);
      mismatches++;
      final_report;
   end

   initial
   begin
      do_reset;
      check(obs, 16'ha464);
      check({15'h0000, wideband_chroma_filter_o}, 16'h0001);
      foreach (ROWS[i])
      begin
         wr(ROWS[i][39:32], ROWS[i][31:24]);
         check(obs, ROWS[i][15:0]);
         rd(ROWS[i][39:32]);
         check({8'h00, rdata_o}, {8'h00, ROWS[i][23:16]});
      end
      check({15'h0000, wideband_chroma_filter_o}, 16'h0000);
      // Offsets now -128 on start and +127 on stop
      vb(10'd200, 10'd20, 10'd100, 1'b1);
      check({5'h00, vblank_start_line_o}, 16'd72);
      check({5'h00, vblank_stop_line_o}, 16'd147);
      check({14'h0000, vertical_blank_output_o, luma_bypass_active_o}, 16'h0003);
      vb(10'd200, 10'd20, 10'd147, 1'b1);
      check({14'h0000, vertical_blank_output_o, luma_bypass_active_o}, 16'h0000);
      vb(10'd200, 10'd20, 10'd72, 1'b0);
      check({14'h0000, vertical_blank_output_o, luma_bypass_active_o}, 16'h0001);
      pulse_ev(5'h1f);
      check({8'h00, irq_status_b_o}, 16'h009e);
      wr(8'h1c, 8'h14);
      check({8'h00, irq_status_b_o}, 16'h008a);
      wr(8'h1c, 8'h60);
      check({8'h00, irq_status_b_o}, 16'h008a);
      // A clear landing with a fresh event leaves the bit set
      fork
         wr(8'h1c, 8'h08);
         pulse_ev(5'h04);
      join
      check({8'h00, irq_status_b_o}, 16'h008a);
      wr(8'h1c, 8'hff);
      check({8'h00, irq_status_b_o}, 16'h0000);
      pulse_ev(5'h02);
      check({8'h00, irq_status_b_o}, 16'h0004);
      wr(8'h1c, 8'h04);
      frame(0);
      frame(525);
      wr(8'h1c, 8'h01);
      check({7'h00, source_type_o, irq_status_b_o}, 16'h0000);
      frame(300);
      check({7'h00, source_type_o, irq_status_b_o}, 16'h0101);
      wr(8'h1c, 8'h01);
      frame(625);
      check({7'h00, source_type_o, irq_status_b_o}, 16'h0001);
      // Clock enable low freezes the bank: a write is lost
      @(posedge clk_i);
      ce_i <= 1'b0;
      wr(8'h17, 8'h00);
      check(obs, 16'hfe0b);
      @(posedge clk_i);
      ce_i <= 1'b1;
      // Second reset in mid-run brings every register back
      do_reset;
      check(obs, 16'ha464);
      check({15'h0000, wideband_chroma_filter_o}, 16'h0001);
      check({8'h00, irq_status_b_o}, 16'h0000);
      for (int i = 0; i < 5; i++)
      begin
         rd(8'h17 + 8'(i));
         check({8'h00, rdata_o}, {8'h00, RST[i]});
      end
      final_report;
   end
endmodule // dcr_regs_bench
